// ### hw/rcl_defines.svh
`ifndef RCL_DEFINES_SVH
`define RCL_DEFINES_SVH

// Clock and timing
`define RCL_CLK_MHZ      250
`define RCL_INIT_MS      20
`define RCL_INIT_CYC     (`RCL_INIT_MS * 1000 * `RCL_CLK_MHZ)
`define RCL_MIN_RST_NS   1000
`define RCL_MIN_RST_CYC  ((`RCL_MIN_RST_NS * `RCL_CLK_MHZ + 999) / 1000)
`define RCL_SLOW_PCT     10

// Addressing and image values
`define RCL_DEF_ADDR     7'h7e
`define RCL_BLANK_WORD   32'hffff_ffff

// Register byte offsets
`define RCL_OFS_CTRL     8'h00
`define RCL_OFS_STATUS   8'h04
`define RCL_OFS_CFG_IDX  8'h08
`define RCL_OFS_CFG_DAT  8'h0c
`define RCL_OFS_IMG_IDX  8'h10
`define RCL_OFS_IMG_DAT  8'h14
`define RCL_OFS_ADDR     8'h18

// Control field positions
`define RCL_CTRL_WP_OFF  0
`define RCL_CTRL_STORE   1
`define RCL_CTRL_ERASE   2

// Status field positions
`define RCL_ST_INIT      0
`define RCL_ST_JTAG      1
`define RCL_ST_SLOW      2
`define RCL_ST_LOG_SUP   3
`define RCL_ST_BLANK     4
`define RCL_ST_BUSY      5

// Configuration word indices
`define RCL_CFG_OE       0
`define RCL_CFG_VAL      1
`define RCL_CFG_MODE     2

// Programming port instructions
`define RCL_IR_FLASH_WR  4'h8
`define RCL_IR_ERASE     4'h9
`define RCL_IR_BYPASS    4'hf
`define RCL_IR_CAPTURE   4'h1

`endif

// ### hw/rcl_pkg.sv
package rcl_pkg;

  typedef enum logic [1:0] {
    RCL_RESET,
    RCL_INIT,
    RCL_RUN
  } rcl_state_t;

  typedef enum logic [2:0] {
    RCL_OP_NONE,
    RCL_OP_RAM_WR,
    RCL_OP_FL_WR,
    RCL_OP_ERASE,
    RCL_OP_LOAD,
    RCL_OP_STORE
  } rcl_op_t;

  typedef enum logic [3:0] {
    RCL_T_TLR, RCL_T_RTI, RCL_T_SELDR, RCL_T_CAPDR,
    RCL_T_SHDR, RCL_T_EX1DR, RCL_T_PSDR, RCL_T_EX2DR,
    RCL_T_UPDR, RCL_T_SELIR, RCL_T_CAPIR, RCL_T_SHIR,
    RCL_T_EX1IR, RCL_T_PSIR, RCL_T_EX2IR, RCL_T_UPIR
  } rcl_tap_t;

endpackage : rcl_pkg

// ### hw/rcl_mem_if.sv
`timescale 1ns/100ps
interface rcl_mem_if #(parameter int AW = 4);
  logic                 start;
  rcl_pkg::rcl_op_t     op;
  logic [AW-1:0]        idx;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  logic [31:0]          cfg_oe;
  logic [31:0]          cfg_val;
  logic [31:0]          cfg_mode;
  logic                 busy;
  logic                 blank;

  modport ctl (output start, op, idx, wdata,
               input  rdata, cfg_oe, cfg_val, cfg_mode, busy, blank);
  modport mem (input  start, op, idx, wdata,
               output rdata, cfg_oe, cfg_val, cfg_mode, busy, blank);
endinterface : rcl_mem_if

// ### hw/rcl_sync.sv
`timescale 1ns/100ps
module rcl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // Two stages per bit; only the second stage is visible outside
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta;
    always_ff @(posedge clk_i) begin
      meta     <= d_i[i];
      q_o[i]   <= meta;
    end
  end
endmodule : rcl_sync

// ### hw/rcl_cfg_mem.sv
`timescale 1ns/100ps
`include "rcl_defines.svh"
module rcl_cfg_mem #(
  parameter int AW = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rcl_mem_if.mem    m
);
  localparam int DEPTH = 1 << AW;

  logic [31:0]      ram   [DEPTH];
  logic [31:0]      flash [DEPTH];
  rcl_pkg::rcl_op_t op;
  logic [AW-1:0]    ptr;
  logic             busy;
  logic             blank;
  logic             walk_go;
  logic             one_go;

  assign walk_go = m.start && !busy && (m.op inside {rcl_pkg::RCL_OP_ERASE,
                   rcl_pkg::RCL_OP_LOAD, rcl_pkg::RCL_OP_STORE});
  assign one_go  = m.start && !busy;

  // Whole-array walks, one word per cycle; requests while busy are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op   <= rcl_pkg::RCL_OP_NONE;
      ptr  <= '0;
      busy <= 1'b0;
    end else if (walk_go) begin
      op   <= m.op;
      ptr  <= '0;
      busy <= 1'b1;
    end else if (busy) begin
      ptr <= ptr + 1'b1;
      if (&ptr) busy <= 1'b0;
    end
  end

  // Blank only if every word still reads erased during the load walk
  always_ff @(posedge clk_i) begin
    if (rst_i)
      blank <= 1'b0;
    else if (walk_go && m.op == rcl_pkg::RCL_OP_LOAD)
      blank <= 1'b1;
    else if (busy && op == rcl_pkg::RCL_OP_LOAD && flash[ptr] != `RCL_BLANK_WORD)
      blank <= 1'b0;
  end

  // Working copy; erased words load as zero, which is the factory default
  always_ff @(posedge clk_i) begin
    if (busy && op == rcl_pkg::RCL_OP_LOAD)
      ram[ptr] <= (flash[ptr] == `RCL_BLANK_WORD) ? 32'h0000_0000 : flash[ptr];
    else if (one_go && m.op == rcl_pkg::RCL_OP_RAM_WR)
      ram[m.idx] <= m.wdata;
  end

  // Nonvolatile copy: never reset, only erased, written or committed
  always_ff @(posedge clk_i) begin
    if (busy && op == rcl_pkg::RCL_OP_STORE)
      flash[ptr] <= ram[ptr];
    else if (busy && op == rcl_pkg::RCL_OP_ERASE)
      flash[ptr] <= `RCL_BLANK_WORD;
    else if (one_go && m.op == rcl_pkg::RCL_OP_FL_WR)
      flash[m.idx] <= m.wdata;
  end

  // Registered read port and live configuration words
  always_ff @(posedge clk_i) begin
    m.rdata    <= ram[m.idx];
    m.cfg_oe   <= ram[`RCL_CFG_OE];
    m.cfg_val  <= ram[`RCL_CFG_VAL];
    m.cfg_mode <= ram[`RCL_CFG_MODE];
  end

  assign m.busy  = busy;
  assign m.blank = blank;
endmodule : rcl_cfg_mem

// ### hw/rcl_top.sv
`timescale 1ns/100ps
`include "rcl_defines.svh"
module rcl_top #(
  parameter int          NGP         = 8,
  parameter int          NPWM        = 8,
  parameter int          AW          = 4,
  parameter int unsigned INIT_CYCLES = `RCL_INIT_CYC
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            por_ok_i,
  input  wire logic            reset_n_i,
  input  wire logic [6:0]      ad_addr_i,
  input  wire logic [1:0]      ad_fault_i,
  input  wire logic [3:0]      gp_in_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  output logic [NPWM-1:0]      fast_pwm_pins_o,
  output logic [NPWM-1:0]      fast_pwm_pins_oe_n_o,
  output logic [NGP-1:0]       general_output_pin_o,
  output logic [NGP-1:0]       general_output_pin_oe_n_o,
  output logic [3:0]           general_input_pin_o,
  output logic                 osc_slow_o,
  output logic                 jtag_en_o,
  output logic                 seq_en_o,
  output logic                 fault_en_o,
  output logic                 log_en_o,
  output logic                 dev_reset_o,
  output logic                 init_busy_o
);
  localparam int DW = AW + 32;

  rcl_mem_if #(.AW(AW)) mif ();

  rcl_pkg::rcl_state_t state;
  rcl_pkg::rcl_tap_t   tap;
  logic [31:0]   init_cnt;
  logic [15:0]   low_cnt;
  logic          dev_rst;
  logic          por_s;
  logic          rstn_s;
  logic [3:0]    gp_s;
  logic          tck_d;
  logic          tck_rise;
  logic          tck_fall;
  logic          jtag_en;
  logic [6:0]    cap_addr;
  logic          wp_off;
  logic          log_sup;
  logic [AW-1:0] cfg_idx;
  logic [AW-1:0] img_idx;
  logic [3:0]    ir;
  logic [3:0]    ir_sh;
  logic [DW-1:0] dr_sh;
  logic          byp;
  logic          tdo;
  logic          tdo_oe;
  logic          jt_req;
  rcl_pkg::rcl_op_t jt_op;
  logic          wb_hit;
  logic          bus_req;
  rcl_pkg::rcl_op_t bus_op;
  logic [AW-1:0] bus_idx;
  logic          img_req;
  logic          prog_ir;

  rcl_sync #(.W(6)) u_sync (
    .clk_i (clk_i),
    .d_i   ({gp_in_i, reset_n_i, por_ok_i}),
    .q_o   ({gp_s, rstn_s, por_s})
  );

  rcl_cfg_mem #(.AW(AW)) u_mem (
    .clk_i (clk_i),
    .rst_i (dev_rst),
    .m     (mif.ctl)
  );

  // Reset pin filter: short glitches never reach the core
  always_ff @(posedge clk_i) begin
    if (rst_i || rstn_s)
      low_cnt <= '0;
    else if (low_cnt != 16'(`RCL_MIN_RST_CYC))
      low_cnt <= low_cnt + 16'h0001;
  end

  // Combined device reset, registered to keep it glitch free
  always_ff @(posedge clk_i) begin
    dev_rst <= rst_i || !por_s || (low_cnt == 16'(`RCL_MIN_RST_CYC));
  end

  // Reset, initialization and run sequence
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      state    <= rcl_pkg::RCL_RESET;
      init_cnt <= '0;
    end else begin
      case (state)
        rcl_pkg::RCL_RESET: state <= rcl_pkg::RCL_INIT;
        rcl_pkg::RCL_INIT: begin
          if (init_cnt != INIT_CYCLES - 1)
            init_cnt <= init_cnt + 32'h0000_0001;
          else if (!mif.busy)
            state <= rcl_pkg::RCL_RUN;
        end
        rcl_pkg::RCL_RUN: state <= rcl_pkg::RCL_RUN;
        default: state <= rcl_pkg::RCL_RESET;
      endcase
    end
  end

  // Address capture at reset exit; faulted select pins give the default
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cap_addr <= `RCL_DEF_ADDR;
    else if (state == rcl_pkg::RCL_RESET && !dev_rst)
      cap_addr <= (|ad_fault_i) ? `RCL_DEF_ADDR : ad_addr_i;
  end

  // Port enable decided once the flash scan is known
  always_ff @(posedge clk_i) begin
    if (dev_rst)
      jtag_en <= 1'b0;
    else if (state == rcl_pkg::RCL_INIT && init_cnt == INIT_CYCLES - 1 && !mif.busy)
      jtag_en <= mif.blank || (cap_addr == `RCL_DEF_ADDR);
  end

  // Bus decode; writes outside normal operation are ignored but acked
  assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign prog_ir = (ir == `RCL_IR_FLASH_WR) || (ir == `RCL_IR_ERASE);

  always_comb begin
    bus_req = 1'b0;
    bus_op  = rcl_pkg::RCL_OP_NONE;
    bus_idx = cfg_idx;
    if (wb_hit && wb_we_i && state == rcl_pkg::RCL_RUN) begin
      case (wb_adr_i)
        `RCL_OFS_CTRL: begin
          if (wb_sel_i[0] && wb_dat_i[`RCL_CTRL_STORE]) begin
            bus_req = 1'b1;
            bus_op  = rcl_pkg::RCL_OP_STORE;
          end else if (wb_sel_i[0] && wb_dat_i[`RCL_CTRL_ERASE] && wp_off) begin
            bus_req = 1'b1;
            bus_op  = rcl_pkg::RCL_OP_ERASE;
          end
        end
        `RCL_OFS_CFG_DAT: begin
          bus_req = (wb_sel_i == 4'hf);
          bus_op  = rcl_pkg::RCL_OP_RAM_WR;
        end
        `RCL_OFS_IMG_DAT: begin
          bus_req = (wb_sel_i == 4'hf) && wp_off;
          bus_op  = rcl_pkg::RCL_OP_FL_WR;
          bus_idx = img_idx;
        end
        default: bus_req = 1'b0;
      endcase
    end
  end

  // Programming port requests win over the bus in the same cycle
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      mif.start <= 1'b0;
      mif.op    <= rcl_pkg::RCL_OP_NONE;
      mif.idx   <= '0;
      mif.wdata <= '0;
    end else begin
      mif.start <= 1'b0;
      if (state == rcl_pkg::RCL_RESET) begin
        mif.start <= 1'b1;
        mif.op    <= rcl_pkg::RCL_OP_LOAD;
      end else if (state == rcl_pkg::RCL_RUN && jt_req) begin
        mif.start <= 1'b1;
        mif.op    <= jt_op;
        mif.idx   <= dr_sh[DW-1:32];
        mif.wdata <= dr_sh[31:0];
      end else if (bus_req) begin
        mif.start <= 1'b1;
        mif.op    <= bus_op;
        mif.idx   <= bus_idx;
        mif.wdata <= wb_dat_i;
      end
    end
  end

  // Flash writes and erases while running, but not stores, suppress logging until reset
  assign img_req = state == rcl_pkg::RCL_RUN && (jt_req || (bus_req &&
                   (bus_op == rcl_pkg::RCL_OP_FL_WR || bus_op == rcl_pkg::RCL_OP_ERASE)));

  always_ff @(posedge clk_i) begin
    if (dev_rst)
      log_sup <= 1'b0;
    else if (img_req)
      log_sup <= 1'b1;
  end

  // Software visible control fields
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      wp_off  <= 1'b0;
      cfg_idx <= '0;
      img_idx <= '0;
    end else if (wb_hit && wb_we_i && state == rcl_pkg::RCL_RUN && wb_sel_i[0]) begin
      case (wb_adr_i)
        `RCL_OFS_CTRL:    wp_off  <= wb_dat_i[`RCL_CTRL_WP_OFF];
        `RCL_OFS_CFG_IDX: cfg_idx <= wb_dat_i[AW-1:0];
        `RCL_OFS_IMG_IDX: img_idx <= wb_dat_i[AW-1:0];
        default:          wp_off  <= wp_off;
      endcase
    end
  end

  // Single-cycle answer; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          `RCL_OFS_CTRL:    wb_dat_o <= {31'h0, wp_off};
          `RCL_OFS_STATUS:  wb_dat_o <= {26'h0, mif.busy, mif.blank, log_sup,
                                         osc_slow_o, jtag_en, state != rcl_pkg::RCL_RUN};
          `RCL_OFS_CFG_IDX: wb_dat_o <= 32'(cfg_idx);
          `RCL_OFS_CFG_DAT: wb_dat_o <= mif.rdata;
          `RCL_OFS_IMG_IDX: wb_dat_o <= 32'(img_idx);
          `RCL_OFS_ADDR:    wb_dat_o <= {25'h0, cap_addr};
          default:          wb_dat_o <= '0;
        endcase
      end
    end
  end

  // TAP next state
  function automatic rcl_pkg::rcl_tap_t tap_next(input rcl_pkg::rcl_tap_t s,
                                                 input logic t);
    case (s)
      rcl_pkg::RCL_T_TLR:   tap_next = t ? rcl_pkg::RCL_T_TLR   : rcl_pkg::RCL_T_RTI;
      rcl_pkg::RCL_T_RTI:   tap_next = t ? rcl_pkg::RCL_T_SELDR : rcl_pkg::RCL_T_RTI;
      rcl_pkg::RCL_T_SELDR: tap_next = t ? rcl_pkg::RCL_T_SELIR : rcl_pkg::RCL_T_CAPDR;
      rcl_pkg::RCL_T_CAPDR: tap_next = t ? rcl_pkg::RCL_T_EX1DR : rcl_pkg::RCL_T_SHDR;
      rcl_pkg::RCL_T_SHDR:  tap_next = t ? rcl_pkg::RCL_T_EX1DR : rcl_pkg::RCL_T_SHDR;
      rcl_pkg::RCL_T_EX1DR: tap_next = t ? rcl_pkg::RCL_T_UPDR  : rcl_pkg::RCL_T_PSDR;
      rcl_pkg::RCL_T_PSDR:  tap_next = t ? rcl_pkg::RCL_T_EX2DR : rcl_pkg::RCL_T_PSDR;
      rcl_pkg::RCL_T_EX2DR: tap_next = t ? rcl_pkg::RCL_T_UPDR  : rcl_pkg::RCL_T_SHDR;
      rcl_pkg::RCL_T_UPDR:  tap_next = t ? rcl_pkg::RCL_T_SELDR : rcl_pkg::RCL_T_RTI;
      rcl_pkg::RCL_T_SELIR: tap_next = t ? rcl_pkg::RCL_T_TLR   : rcl_pkg::RCL_T_CAPIR;
      rcl_pkg::RCL_T_CAPIR: tap_next = t ? rcl_pkg::RCL_T_EX1IR : rcl_pkg::RCL_T_SHIR;
      rcl_pkg::RCL_T_SHIR:  tap_next = t ? rcl_pkg::RCL_T_EX1IR : rcl_pkg::RCL_T_SHIR;
      rcl_pkg::RCL_T_EX1IR: tap_next = t ? rcl_pkg::RCL_T_UPIR  : rcl_pkg::RCL_T_PSIR;
      rcl_pkg::RCL_T_PSIR:  tap_next = t ? rcl_pkg::RCL_T_EX2IR : rcl_pkg::RCL_T_PSIR;
      rcl_pkg::RCL_T_EX2IR: tap_next = t ? rcl_pkg::RCL_T_UPIR  : rcl_pkg::RCL_T_SHIR;
      rcl_pkg::RCL_T_UPIR:  tap_next = t ? rcl_pkg::RCL_T_SELDR : rcl_pkg::RCL_T_RTI;
      default:              tap_next = rcl_pkg::RCL_T_TLR;
    endcase
  endfunction : tap_next

  // Test clock edges, taken from the second synchroniser stage only
  always_ff @(posedge clk_i) begin
    tck_d <= gp_s[0];
  end
  assign tck_rise = gp_s[0] && !tck_d;
  assign tck_fall = !gp_s[0] && tck_d;

  // TAP; unknown instructions fall to bypass, so no boundary scan
  always_ff @(posedge clk_i) begin
    if (dev_rst || !jtag_en) begin
      tap    <= rcl_pkg::RCL_T_TLR;
      ir     <= `RCL_IR_BYPASS;
      ir_sh  <= '0;
      dr_sh  <= '0;
      byp    <= 1'b0;
      jt_req <= 1'b0;
      jt_op  <= rcl_pkg::RCL_OP_NONE;
    end else begin
      jt_req <= 1'b0;
      if (tck_rise) begin
        tap <= tap_next(tap, gp_s[1]);
        case (tap)
          rcl_pkg::RCL_T_TLR:   ir    <= `RCL_IR_BYPASS;
          rcl_pkg::RCL_T_CAPIR: ir_sh <= `RCL_IR_CAPTURE;
          rcl_pkg::RCL_T_SHIR:  ir_sh <= {gp_s[2], ir_sh[3:1]};
          rcl_pkg::RCL_T_UPIR:  ir    <= ir_sh;
          rcl_pkg::RCL_T_CAPDR: byp   <= 1'b0;
          rcl_pkg::RCL_T_SHDR: begin
            if (prog_ir) dr_sh <= {gp_s[2], dr_sh[DW-1:1]};
            else         byp   <= gp_s[2];
          end
          rcl_pkg::RCL_T_UPDR: begin
            jt_req <= prog_ir;
            jt_op  <= (ir == `RCL_IR_ERASE) ? rcl_pkg::RCL_OP_ERASE
                                             : rcl_pkg::RCL_OP_FL_WR;
          end
          default: byp <= byp;
        endcase
      end
    end
  end

  // Test data out changes on the falling test clock edge
  always_ff @(posedge clk_i) begin
    if (dev_rst || !jtag_en) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (tap == rcl_pkg::RCL_T_SHIR) ? ir_sh[0] : prog_ir ? dr_sh[0] : byp;
      tdo_oe <= (tap == rcl_pkg::RCL_T_SHIR) || (tap == rcl_pkg::RCL_T_SHDR);
    end
  end

  // Pin drive; factory config of all zeros floats every general output except pin 3 while the test port shifts; the PWM pins stay driven
  always_ff @(posedge clk_i) begin
    if (dev_rst || state != rcl_pkg::RCL_RUN) begin
      fast_pwm_pins_o           <= '0;
      fast_pwm_pins_oe_n_o      <= '0;
      general_output_pin_o      <= '0;
      general_output_pin_oe_n_o <= '1;
      general_input_pin_o       <= '0;
    end else begin
      fast_pwm_pins_o           <= mif.cfg_val[NGP +: NPWM];
      fast_pwm_pins_oe_n_o      <= '0;
      general_output_pin_o      <= mif.cfg_val[NGP-1:0];
      general_output_pin_oe_n_o <= ~mif.cfg_oe[NGP-1:0];
      general_input_pin_o       <= gp_s;
      if (jtag_en) begin
        general_output_pin_oe_n_o[3:0] <= {!tdo_oe, 3'b111};
        general_output_pin_o[3]        <= tdo;
        general_input_pin_o            <= '0;
      end
    end
  end

  // Status outputs; the slow request simply follows the port enable
  always_ff @(posedge clk_i) begin
    osc_slow_o  <= jtag_en;
    jtag_en_o   <= jtag_en;
    seq_en_o    <= state == rcl_pkg::RCL_RUN && mif.cfg_mode[0];
    fault_en_o  <= state == rcl_pkg::RCL_RUN && mif.cfg_mode[1];
    log_en_o    <= state == rcl_pkg::RCL_RUN && !log_sup;
    dev_reset_o <= state == rcl_pkg::RCL_RESET;
    init_busy_o <= state != rcl_pkg::RCL_RUN;
  end

  // Checks
  sequence s_img_wr;
    img_req ##1 1'b1;
  endsequence

  sequence s_rst_exit;
    (state == rcl_pkg::RCL_RESET) && !dev_rst;
  endsequence

  por_hold_a: assert property (@(posedge clk_i) !por_s |=> ##1 state == rcl_pkg::RCL_RESET)
    else $error("supply low but not in reset");
  pin_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_cnt == 16'(`RCL_MIN_RST_CYC) |=> ##2 dev_reset_o)
    else $error("reset pin low but device running");
  rst_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rst_exit |=> state == rcl_pkg::RCL_INIT ##1 init_cnt == 32'h0000_0001)
    else $error("reset exit did not start init");
  init_len_a: assert property (@(posedge clk_i) disable iff (dev_rst)
    state == rcl_pkg::RCL_INIT && init_cnt != INIT_CYCLES - 1 |=> state == rcl_pkg::RCL_INIT)
    else $error("init ended early");
  init_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == rcl_pkg::RCL_INIT |=> fast_pwm_pins_oe_n_o == '0 && fast_pwm_pins_o == '0
    && general_output_pin_oe_n_o == '1)
    else $error("pins not safe during init");
  osc_slow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(jtag_en) |=> osc_slow_o && jtag_en_o)
    else $error("clock not slowed with port enabled");
  jtag_pick_a: assert property (@(posedge clk_i) disable iff (dev_rst)
    $rose(state == rcl_pkg::RCL_RUN) |-> jtag_en == (mif.blank || cap_addr == `RCL_DEF_ADDR))
    else $error("port enable decision wrong");
  shared_pin_a: assert property (@(posedge clk_i) disable iff (dev_rst)
    jtag_en && state == rcl_pkg::RCL_RUN |=> general_output_pin_oe_n_o[2:0] == 3'b111)
    else $error("shared pin driven while port enabled");
  ram_only_a: assert property (@(posedge clk_i) disable iff (dev_rst)
    bus_req && bus_op == rcl_pkg::RCL_OP_RAM_WR && !jt_req
    |=> mif.start && mif.op == rcl_pkg::RCL_OP_RAM_WR)
    else $error("parameter write not routed to ram");
  store_cmd_a: assert property (@(posedge clk_i) disable iff (dev_rst)
    bus_req && bus_op == rcl_pkg::RCL_OP_STORE && !jt_req
    |=> mif.op == rcl_pkg::RCL_OP_STORE)
    else $error("save command not issued");
  log_off_a: assert property (@(posedge clk_i) disable iff (dev_rst)
    s_img_wr |=> !log_en_o)
    else $error("logging active after image update");
endmodule : rcl_top

// ### verif/rcl_host.sv
`timescale 1ns/100ps
// Register bus host standing on the far side of the block
module rcl_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  // Idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = 47'h0;
  end
  // Caller waits out init and orders unprotect, erase, image, reset
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hf, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o} <= 2'h0;
    dat_o <= ~d;  // Released data must not look valid
  endtask : xfer
endmodule : rcl_host

// ### verif/rcl_top_tb.sv
`timescale 1ns/100ps
`include "rcl_defines.svh"
module rcl_top_tb;
  localparam int IC = 64;
  logic clk_i = 0, rst_i = 1, por_ok_i = 1, reset_n_i = 1;
  logic [6:0]  ad_addr_i = 7'h00, a;
  logic [1:0]  ad_fault_i = 2'h0;
  logic [3:0]  gp_in_i = 4'h0, general_input_pin_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, fast_pwm_pins_o, fast_pwm_pins_oe_n_o;
  logic [7:0]  general_output_pin_o, general_output_pin_oe_n_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic osc_slow_o, jtag_en_o, seq_en_o, fault_en_o, log_en_o, dev_reset_o, init_busy_o;
  int seed = 32'he0c7, miscompares = 0, cmp_count = 0, cycles = 0, n;
  int fl[3], ram[3];
  logic [35:0] dr, jq;
  always #2 clk_i = ~clk_i;
  rcl_top #(.INIT_CYCLES(IC)) dut_u (.clk_i, .rst_i, .por_ok_i, .reset_n_i, .ad_addr_i,
    .ad_fault_i, .gp_in_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .fast_pwm_pins_o, .fast_pwm_pins_oe_n_o,
    .general_output_pin_o, .general_output_pin_oe_n_o, .general_input_pin_o,
    .osc_slow_o, .jtag_en_o, .seq_en_o, .fault_en_o, .log_en_o, .dev_reset_o,
    .init_busy_o);
  rcl_host host_u (.clk_i, .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task results;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      results();
    end
  end
  task wr(input logic [7:0] ad, input logic [31:0] d);
    host_u.xfer(1'b1, ad, d, q);
  endtask : wr
  // Poll until flash walk is over
  task idle;
    do host_u.xfer(1'b0, `RCL_OFS_STATUS, 32'h0, q); while (q[`RCL_ST_BUSY] !== 1'b0);
  endtask : idle
  // Reset, check pins during init, then wait for run
  task boot(input logic [6:0] ad, input logic [1:0] f);
    @(posedge clk_i);
    {ad_addr_i, ad_fault_i, rst_i, gp_in_i} <= {ad, f, 1'b1, 4'($random(seed))};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({fast_pwm_pins_o, fast_pwm_pins_oe_n_o, general_output_pin_oe_n_o}, 24'hff);
    n = 0;
    while (init_busy_o !== 1'b0) begin
      @(posedge clk_i);
      n++;
    end
    chk(n > IC - 5, 1);
  endtask : boot
  // Pins follow the active configuration words
  task outs(input int w[3]);
    chk(general_output_pin_oe_n_o, 8'(~w[0][7:0]));
    chk(general_output_pin_o & w[0][7:0], w[1][7:0] & w[0][7:0]);
    chk({fast_pwm_pins_o, seq_en_o, fault_en_o}, {w[1][15:8], w[2][0], w[2][1]});
  endtask : outs
  // Programmer walk, LSB first; slow test clock so tdo has settled before each rise
  task jtag(input logic [35:0] ms, input logic [35:0] di, input int n);
    for (int i = 0; i < n; i++) begin
      gp_in_i[2:0] <= {di[i], ms[i], 1'b0};
      repeat (6) @(posedge clk_i);
      jq[i] = general_output_pin_o[3];
      gp_in_i[0] <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
  endtask : jtag
  initial begin
    boot(7'h7e, 2'h0);
    chk({jtag_en_o, osc_slow_o, general_input_pin_o}, 6'h30);
    wr(`RCL_OFS_CTRL, 32'h1);
    wr(`RCL_OFS_CTRL, 32'h5);
    idle();
    for (int i = 0; i < 3; i++) begin
      fl[i] = $random(seed);
      wr(`RCL_OFS_IMG_IDX, i);
      wr(`RCL_OFS_IMG_DAT, fl[i]);
      idle();
    end
    chk(log_en_o, 1'b0);
    a = 7'($random(seed)) & 7'h3f;
    boot(a, 2'h0);
    chk({jtag_en_o, log_en_o, general_input_pin_o}, {2'h1, gp_in_i});
    outs(fl);
    ram = fl;
    ram[1] = $random(seed);
    wr(`RCL_OFS_CFG_IDX, 32'h1);
    wr(`RCL_OFS_CFG_DAT, ram[1]);
    repeat (3) @(posedge clk_i);
    outs(ram);
    boot(a, 2'h0);
    outs(fl);
    wr(`RCL_OFS_CFG_IDX, 32'h1);
    wr(`RCL_OFS_CFG_DAT, ram[1]);
    wr(`RCL_OFS_CTRL, 32'h2);
    idle();
    boot(a, 2'h0);
    outs(ram);
    boot(a, 2'h1);
    chk(jtag_en_o, 1'b1);
    // Erased flash: port comes up with a normal address, pins at factory default
    wr(`RCL_OFS_CTRL, 32'h1);
    wr(`RCL_OFS_CTRL, 32'h5);
    idle();
    boot(a, 2'h0);
    chk(jtag_en_o, 1'b1);
    ram = '{0, 0, 0};
    outs(ram);
    // Flash word written through the test port, then picked up at reset
    jtag(36'h6, 36'h0, 5);
    jtag(36'h8, 36'h8, 4);
    chk(jq[3:0], `RCL_IR_CAPTURE);
    jtag(36'h3, 36'h0, 4);
    dr = {4'h1, 32'($random(seed))};
    jtag(36'h8_0000_0000, dr, 36);
    jtag(36'h1, 36'h0, 2);
    repeat (4) @(posedge clk_i);
    chk(log_en_o, 1'b0);
    boot(a, 2'h0);
    chk(jtag_en_o, 1'b0);
    ram = '{0, dr[31:0], 0};
    outs(ram);
    reset_n_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk(dev_reset_o, 1'b1);
    reset_n_i <= 1'b1;
    n = 0;
    while (dev_reset_o !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk(dev_reset_o, 1'b0);
    por_ok_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk(dev_reset_o, 1'b1);
    results();
  end
endmodule : rcl_top_tb
